// *** design/scbp_pkg.sv ***
// Constants and types shared by the scan player and its starter
// Behaviour
// - Instruction scans lead with header one bits
// - Starter sets header instruction count downstream
// - Instruction scans end with trailer one bits
// - Starter sets trailer instruction count upstream
// - Data scans lead with following-device zero bits
// - Data scans end with preceding-device zero bits
// - Configuration data scans add alignment zero bits
// - Alignment count zero or thirty-two minus modulo
// - Rewind stream pointer, then start with counts
// - All counts zero adds no bits
// - Chain devices bypass with one-bit data register
package scbp_pkg;

  localparam int CLK_NS       = 8;
  localparam int TCK_HALF_NS  = 32;
  localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] TCK_HALF = 4'(TCK_HALF_CYC);
  localparam logic [3:0] TCK_LAST = 4'(2 * TCK_HALF_CYC - 1);

  localparam int PAD_W  = 8;
  localparam int WORD_W = 16;
  localparam int LEN_W  = 14;
  localparam int OP_LSB = 14;
  localparam int CNT_W  = 16;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;

  // Command word: op in the top two bits, payload bit count below
  localparam logic [1:0] OP_END  = 2'h0;
  localparam logic [1:0] OP_IR   = 2'h1;
  localparam logic [1:0] OP_DR   = 2'h2;
  localparam logic [1:0] OP_FPGA = 2'h3;

  // Test logic reset: five TMS ones then one zero into run/idle
  localparam logic [2:0] TRST_ONES = 3'h5;
  // Walk from run/idle to shift, TMS LSB first
  localparam logic [3:0] IR_PRE_TMS = 4'h3;
  localparam logic [2:0] IR_PRE_LAST = 3'h3;
  localparam logic [3:0] DR_PRE_TMS = 4'h1;
  localparam logic [2:0] DR_PRE_LAST = 3'h2;
  localparam logic [2:0] POST_LAST = 3'h1;

  localparam logic [PAD_W-1:0] ALIGN_MOD = 8'h20;

  typedef enum logic [5:0] {
    PS_IDLE  = 6'h01,
    PS_TRST  = 6'h02,
    PS_FETCH = 6'h04,
    PS_PRE   = 6'h08,
    PS_SHIFT = 6'h10,
    PS_POST  = 6'h20
  } scbp_pst_e;

  typedef enum logic [2:0] {
    SS_IDLE   = 3'h1,
    SS_START  = 3'h2,
    SS_STREAM = 3'h4
  } scbp_sst_e;

endpackage

// *** design/scbp_if.sv ***
// Start, command stream and status link between starter and player
`timescale 1ns/10ps
`default_nettype none
interface scbp_if;
  import scbp_pkg::*;

  logic              start;
  logic [PAD_W-1:0]  header_instr_pad_count;
  logic [PAD_W-1:0]  trailer_instr_pad_count;
  logic [PAD_W-1:0]  header_data_pad_count;
  logic [PAD_W-1:0]  trailer_data_pad_count;
  logic [PAD_W-1:0]  fpga_align_pad_count;
  logic [WORD_W-1:0] cmd_data;
  logic              cmd_valid;
  logic              cmd_ready;
  logic              busy;
  logic              done;
  logic [WORD_W-1:0] tdo_word;

  modport player (
    input  start, header_instr_pad_count, trailer_instr_pad_count,
           header_data_pad_count, trailer_data_pad_count, fpga_align_pad_count,
           cmd_data, cmd_valid,
    output cmd_ready, busy, done, tdo_word
  );

  modport starter (
    output start, header_instr_pad_count, trailer_instr_pad_count,
           header_data_pad_count, trailer_data_pad_count, fpga_align_pad_count,
           cmd_data, cmd_valid,
    input  cmd_ready, busy, done, tdo_word
  );
endinterface
`default_nettype wire

// *** design/scbp_player.sv ***
// Scan chain player that pads each scan for bypassed chain devices
`timescale 1ns/10ps
`default_nettype none
module scbp_player
  import scbp_pkg::*;
(
  input  wire logic  sys_clk_i,
  input  wire logic  nrst_i,
  scbp_if.player     lnk,
  input  wire logic  tdo_i,
  output logic       tck_o,
  output logic       tms_o,
  output logic       tdi_o
);

  typedef struct packed {
    scbp_pst_e         st;
    logic [3:0]        ph;
    logic              step;
    logic              capt;
    logic              tck;
    logic              tms;
    logic              tdi;
    logic [2:0]        idx;
    logic [PAD_W-1:0]  hir;
    logic [PAD_W-1:0]  tir;
    logic [PAD_W-1:0]  hdr;
    logic [PAD_W-1:0]  tdr;
    logic [PAD_W-1:0]  algn;
    logic [1:0]        op;
    logic [CNT_W-1:0]  head;
    logic [CNT_W-1:0]  hl;
    logic [CNT_W-1:0]  tot;
    logic [CNT_W-1:0]  pos;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] fd0;
    logic [WORD_W-1:0] fd1;
    logic [1:0]        fcnt;
    logic              rdy;
    logic              busy;
    logic              done;
    logic [WORD_W-1:0] tdo_word;
    logic              tdo_m;
    logic              tdo_s;
  } scbp_ply_s;

  scbp_ply_s s;
  scbp_ply_s next_s;

  always_comb begin
    logic              pop;
    logic              push;
    logic [1:0]        c;
    logic [LEN_W-1:0]  len;
    logic [CNT_W-1:0]  hd;
    logic [CNT_W-1:0]  tl;
    logic [3:0]        bi;
    logic              padv;
    pop    = 1'b0;
    push   = lnk.cmd_valid && s.rdy;
    c      = s.fcnt;
    len    = '0;
    hd     = '0;
    tl     = '0;
    bi     = '0;
    padv   = (s.op == OP_IR);
    next_s = s;
    next_s.done  = 1'b0;
    next_s.tdo_m = tdo_i;
    next_s.tdo_s = s.tdo_m;

    // Test clock: low for the first half of a step, high for the second
    if (s.step) begin
      next_s.ph = s.ph + 4'h1;
      if (s.ph == TCK_HALF - 4'h1) begin
        next_s.tck = 1'b1;
      end
      if (s.ph == TCK_HALF && s.capt) begin
        next_s.tdo_word = {s.tdo_s, s.tdo_word[WORD_W-1:1]};
      end
      if (s.ph == TCK_LAST) begin
        next_s.tck  = 1'b0;
        next_s.step = 1'b0;
        next_s.ph   = '0;
      end
    end

    unique case (s.st)
      PS_IDLE: begin
        if (lnk.start) begin
          next_s.hir  = lnk.header_instr_pad_count;
          next_s.tir  = lnk.trailer_instr_pad_count;
          next_s.hdr  = lnk.header_data_pad_count;
          next_s.tdr  = lnk.trailer_data_pad_count;
          next_s.algn = lnk.fpga_align_pad_count;
          next_s.busy = 1'b1;
          next_s.idx  = '0;
          next_s.st   = PS_TRST;
          c           = '0;
        end
      end
      PS_TRST: begin
        if (!s.step) begin
          next_s.step = 1'b1;
          next_s.capt = 1'b0;
          next_s.tdi  = 1'b0;
          next_s.tms  = (s.idx < TRST_ONES);
          next_s.idx  = s.idx + 3'h1;
          if (s.idx == TRST_ONES) begin
            next_s.st = PS_FETCH;
          end
        end
      end
      PS_FETCH: begin
        if (!s.step && s.fcnt != 2'h0) begin
          pop       = 1'b1;
          next_s.op = s.fd0[WORD_W-1:OP_LSB];
          len       = s.fd0[LEN_W-1:0];
          unique case (s.fd0[WORD_W-1:OP_LSB])
            OP_IR: begin
              hd = CNT_W'(s.hir);
              tl = CNT_W'(s.tir);
            end
            OP_DR: begin
              hd = CNT_W'(s.hdr);
              tl = CNT_W'(s.tdr);
            end
            OP_FPGA: begin
              hd = CNT_W'(s.hdr) + CNT_W'(s.algn);
              tl = CNT_W'(s.tdr);
            end
            OP_END: begin
              hd = '0;
              tl = '0;
            end
          endcase
          next_s.head = hd;
          next_s.hl   = hd + CNT_W'(len);
          next_s.tot  = hd + CNT_W'(len) + tl;
          next_s.idx  = '0;
          if (s.fd0[WORD_W-1:OP_LSB] == OP_END) begin
            next_s.st   = PS_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end else if ((hd + CNT_W'(len) + tl) != '0) begin
            next_s.st = PS_PRE;
          end
        end
      end
      PS_PRE: begin
        if (!s.step) begin
          next_s.step = 1'b1;
          next_s.capt = 1'b0;
          next_s.tdi  = 1'b0;
          next_s.idx  = s.idx + 3'h1;
          if (s.op == OP_IR) begin
            next_s.tms = IR_PRE_TMS[s.idx[1:0]];
            if (s.idx == IR_PRE_LAST) begin
              next_s.st = PS_SHIFT;
            end
          end else begin
            next_s.tms = DR_PRE_TMS[s.idx[1:0]];
            if (s.idx == DR_PRE_LAST) begin
              next_s.st = PS_SHIFT;
            end
          end
          next_s.pos = '0;
        end
      end
      PS_SHIFT: begin
        if (!s.step) begin
          bi = 4'(s.pos - s.head);
          if (s.pos < s.head) begin
            next_s.step = 1'b1;
            next_s.capt = 1'b0;
            next_s.tdi  = padv;
          end else if (s.pos < s.hl) begin
            if (bi != 4'h0) begin
              next_s.step = 1'b1;
              next_s.capt = 1'b1;
              next_s.tdi  = s.word[bi];
            end else if (s.fcnt != 2'h0) begin
              pop         = 1'b1;
              next_s.word = s.fd0;
              next_s.step = 1'b1;
              next_s.capt = 1'b1;
              next_s.tdi  = s.fd0[0];
            end
          end else begin
            next_s.step = 1'b1;
            next_s.capt = 1'b0;
            next_s.tdi  = padv;
          end
          if (next_s.step) begin
            next_s.tms = (s.pos == s.tot - CNT_W'(1));
            next_s.pos = s.pos + CNT_W'(1);
            if (s.pos == s.tot - CNT_W'(1)) begin
              next_s.st  = PS_POST;
              next_s.idx = '0;
            end
          end
        end
      end
      PS_POST: begin
        if (!s.step) begin
          next_s.step = 1'b1;
          next_s.capt = 1'b0;
          next_s.tdi  = 1'b0;
          next_s.tms  = (s.idx == 3'h0);
          next_s.idx  = s.idx + 3'h1;
          if (s.idx == POST_LAST) begin
            next_s.st = PS_FETCH;
          end
        end
      end
    endcase

    // Two-entry command buffer, pop from the head then append
    if (pop) begin
      next_s.fd0 = s.fd1;
      c          = c - 2'h1;
    end
    if (push) begin
      if (c == 2'h0) begin
        next_s.fd0 = lnk.cmd_data;
      end else begin
        next_s.fd1 = lnk.cmd_data;
      end
      c = c + 2'h1;
    end
    next_s.fcnt = c;
    next_s.rdy  = (c != 2'h2);
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s     <= '0;
      s.st  <= PS_IDLE;
      s.rdy <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign tck_o         = s.tck;
  assign tms_o         = s.tms;
  assign tdi_o         = s.tdi;
  assign lnk.cmd_ready = s.rdy;
  assign lnk.busy      = s.busy;
  assign lnk.done      = s.done;
  assign lnk.tdo_word  = s.tdo_word;

endmodule
`default_nettype wire

// *** design/scbp_starter.sv ***
// Starter that stores the command stream and launches the player
`timescale 1ns/10ps
`default_nettype none
module scbp_starter
  import scbp_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  scbp_if.starter                lnk,
  input  wire logic              mem_we_i,
  input  wire logic [MEM_AW-1:0] mem_addr_i,
  input  wire logic [WORD_W-1:0] mem_data_i,
  input  wire logic              run_i,
  input  wire logic [PAD_W-1:0]  prec_devs_i,
  input  wire logic [PAD_W-1:0]  foll_devs_i,
  input  wire logic [PAD_W-1:0]  prec_ir_len_i,
  input  wire logic [PAD_W-1:0]  foll_ir_len_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [WORD_W-1:0]      tdo_word_o
);

  typedef struct packed {
    scbp_sst_e         st;
    logic [MEM_AW-1:0] ptr;
    logic              vld;
    logic [WORD_W-1:0] dat;
    logic              start;
    logic [PAD_W-1:0]  hir;
    logic [PAD_W-1:0]  tir;
    logic [PAD_W-1:0]  hdr;
    logic [PAD_W-1:0]  tdr;
    logic [PAD_W-1:0]  algn;
    logic              busy;
    logic              done;
    logic [WORD_W-1:0] tdo_word;
  } scbp_str_s;

  scbp_str_s         s;
  scbp_str_s         next_s;
  logic [WORD_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge sys_clk_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_data_i;
    end
  end

  always_comb begin
    next_s = s;
    next_s.start = 1'b0;
    next_s.done  = 1'b0;
    unique case (s.st)
      SS_IDLE: begin
        if (run_i) begin
          next_s.ptr  = '0;
          next_s.hir  = foll_ir_len_i;
          next_s.tir  = prec_ir_len_i;
          next_s.hdr  = foll_devs_i;
          next_s.tdr  = prec_devs_i;
          if (prec_devs_i == '0) begin
            next_s.algn = '0;
          end else begin
            next_s.algn = ALIGN_MOD - {3'h0, prec_devs_i[4:0]};
          end
          next_s.busy = 1'b1;
          next_s.st   = SS_START;
        end
      end
      SS_START: begin
        next_s.start = 1'b1;
        next_s.st    = SS_STREAM;
      end
      SS_STREAM: begin
        if (!s.vld || lnk.cmd_ready) begin
          next_s.vld = 1'b1;
          next_s.dat = mem[s.ptr];
          next_s.ptr = s.ptr + MEM_AW'(1);
        end
        if (lnk.done) begin
          next_s.vld      = 1'b0;
          next_s.busy     = 1'b0;
          next_s.done     = 1'b1;
          next_s.tdo_word = lnk.tdo_word;
          next_s.st       = SS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s    <= '0;
      s.st <= SS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign lnk.start                   = s.start;
  assign lnk.header_instr_pad_count  = s.hir;
  assign lnk.trailer_instr_pad_count = s.tir;
  assign lnk.header_data_pad_count   = s.hdr;
  assign lnk.trailer_data_pad_count  = s.tdr;
  assign lnk.fpga_align_pad_count    = s.algn;
  assign lnk.cmd_data                = s.dat;
  assign lnk.cmd_valid               = s.vld;
  assign busy_o                      = s.busy;
  assign done_o                      = s.done;
  assign tdo_word_o                  = s.tdo_word;

endmodule
`default_nettype wire

// *** tb/scbp_properties.sv ***
// Properties on the link between the starter and the padded scan player
`timescale 1ns/10ps
`default_nettype none
module scbp_properties
  import scbp_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              nrst_i,
  input wire logic              start,
  input wire logic [PAD_W-1:0]  header_instr_pad_count,
  input wire logic [PAD_W-1:0]  trailer_instr_pad_count,
  input wire logic [PAD_W-1:0]  header_data_pad_count,
  input wire logic [PAD_W-1:0]  trailer_data_pad_count,
  input wire logic [PAD_W-1:0]  fpga_align_pad_count,
  input wire logic [WORD_W-1:0] cmd_data,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire logic              busy,
  input wire logic              done,
  input wire logic [WORD_W-1:0] tdo_word
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_start_pulse: assert property (start |=> !start)
    else $error("start longer than one cycle");
  a_start_busy: assert property (start |=> busy)
    else $error("busy did not follow start");
  a_start_idle: assert property (start |-> !busy)
    else $error("start issued while busy");
  a_counts_held: assert property (busy && $past(busy) |->
    $stable({header_instr_pad_count, trailer_instr_pad_count, header_data_pad_count,
             trailer_data_pad_count, fpga_align_pad_count}))
    else $error("pad counts changed during a run");
  a_stream_holds: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_data))
    else $error("command word dropped before taken");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_idle: assert property (done |=> !busy)
    else $error("busy still high after done");
  a_align_range: assert property (start |-> fpga_align_pad_count <= ALIGN_MOD)
    else $error("alignment count above thirty-two");
  a_tdo_quiet: assert property (!busy && !start |=> $stable(tdo_word))
    else $error("captured word moved while idle");
endmodule
`default_nettype wire

// *** tb/scbp_tb_top.sv ***
// Testbench driving the starter and watching the scan link
`timescale 1ns/10ps
`default_nettype none
module scbp_tb_top;
  import scbp_pkg::*;
  logic              sys_clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              mem_we_i = 1'b0;
  logic [MEM_AW-1:0] mem_addr_i = '0;
  logic [WORD_W-1:0] mem_data_i = '0;
  logic              run_i = 1'b0;
  logic [PAD_W-1:0]  prec_devs_i = '0;
  logic [PAD_W-1:0]  foll_devs_i = '0;
  logic [PAD_W-1:0]  prec_ir_len_i = '0;
  logic [PAD_W-1:0]  foll_ir_len_i = '0;
  logic              busy_o;
  logic              done_o;
  logic [WORD_W-1:0] tdo_word_o;
  logic              tck_o;
  logic              tms_o;
  logic              tdi_o;
  logic              tdo_i;
  logic              tck_q = 1'b0;
  logic [1:0]        got[$];
  logic [1:0]        exp_q[$];
  logic [15:0]       prog[8] = '{16'h4002, 16'h0001, 16'h8003, 16'h0005,
                                 16'hc001, 16'h0001, 16'h8000, 16'h0000};
  int                fails = 0;
  int                num_checks = 0;
  int                hir, tir, hdr, tdr, aln;

  scbp_if lnk();
  scbp_starter i_scbp_starter (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .lnk(lnk),
    .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_data_i(mem_data_i), .run_i(run_i),
    .prec_devs_i(prec_devs_i), .foll_devs_i(foll_devs_i), .prec_ir_len_i(prec_ir_len_i),
    .foll_ir_len_i(foll_ir_len_i), .busy_o(busy_o), .done_o(done_o), .tdo_word_o(tdo_word_o));
  scbp_player i_scbp_player (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .lnk(lnk),
    .tdo_i(tdo_i), .tck_o(tck_o), .tms_o(tms_o), .tdi_o(tdi_o));
  scbp_properties i_scbp_properties (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .start(lnk.start), .header_instr_pad_count(lnk.header_instr_pad_count),
    .trailer_instr_pad_count(lnk.trailer_instr_pad_count),
    .header_data_pad_count(lnk.header_data_pad_count),
    .trailer_data_pad_count(lnk.trailer_data_pad_count),
    .fpga_align_pad_count(lnk.fpga_align_pad_count), .cmd_data(lnk.cmd_data),
    .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .busy(lnk.busy),
    .done(lnk.done), .tdo_word(lnk.tdo_word));

  // Chain stand-in: scanned bits come straight back
  assign tdo_i = tdi_o;

  always #4 sys_clk_i = ~sys_clk_i;

  // Record TMS and TDI at every rising test clock edge
  always @(posedge sys_clk_i) begin
    tck_q <= tck_o;
    if (tck_o && !tck_q) got.push_back({tms_o, tdi_o});
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic push_tms(input logic [3:0] seq, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back({seq[i], 1'b0});
  endtask

  task automatic scan(input logic [1:0] op, input int len, input logic [15:0] pay);
    int   h, t, n;
    logic pv;
    pv = (op == OP_IR);
    h = pv ? hir : (op == OP_FPGA ? hdr + aln : hdr);
    t = pv ? tir : tdr;
    n = h + len + t;
    if (n == 0) return;
    if (pv) push_tms(4'h3, 4);
    else push_tms(4'h1, 3);
    for (int i = 0; i < n; i++)
      exp_q.push_back({i == n - 1, (i < h || i >= h + len) ? pv : pay[i - h]});
    push_tms(4'h1, 2);
  endtask

  // One run with the target placed by the chain figures given
  task automatic run(input int pd, input int fd, input int pil, input int fil);
    int k;
    hir = fil;
    tir = pil;
    hdr = fd;
    tdr = pd;
    aln = (pd == 0) ? 0 : 32 - pd % 32;
    exp_q.delete();
    push_tms(4'hf, 4);
    push_tms(4'h1, 2);
    scan(OP_IR, 2, 16'h0001);
    scan(OP_DR, 3, 16'h0005);
    scan(OP_FPGA, 1, 16'h0001);
    scan(OP_DR, 0, 16'h0000);
    @(posedge sys_clk_i);
    got.delete();
    prec_devs_i <= 8'(pd);
    foll_devs_i <= 8'(fd);
    prec_ir_len_i <= 8'(pil);
    foll_ir_len_i <= 8'(fil);
    run_i <= 1'b1;
    @(posedge sys_clk_i);
    run_i <= 1'b0;
    k = 0;
    while (lnk.start !== 1'b1 && k < 10) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 10) begin
      fails++;
      results();
    end
    check(lnk.header_instr_pad_count, fil);
    check(lnk.trailer_instr_pad_count, pil);
    check(lnk.header_data_pad_count, fd);
    check(lnk.trailer_data_pad_count, pd);
    check(lnk.fpga_align_pad_count, aln);
    // A second run request mid-run must change nothing
    @(posedge sys_clk_i);
    run_i <= 1'b1;
    foll_devs_i <= 8'h07;
    @(posedge sys_clk_i);
    run_i <= 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 20000) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 20000) begin
      fails++;
      results();
    end
    check(got.size(), exp_q.size());
    for (int i = 0; i < got.size() && i < exp_q.size(); i++)
      check(got[i], exp_q[i]);
    check(tdo_word_o[15:10], 6'b110101);
    @(negedge sys_clk_i);
    check(busy_o, 1'b0);
    $display("test done: prec %0d foll %0d", pd, fd);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    // Words past the program read as end commands, so prefetch never sees unknowns
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk_i);
      mem_we_i <= 1'b1;
      mem_addr_i <= 8'(i);
      mem_data_i <= (i < 8) ? prog[i[2:0]] : 16'h0000;
    end
    @(posedge sys_clk_i);
    mem_we_i <= 1'b0;
    run(1, 2, 5, 3);
    run(0, 0, 0, 0);
    run(40, 0, 0, 0);
    results();
  end
endmodule
`default_nettype wire
